// [bench/rtc_device_model.sv]
// Behavioural clock device on the controller pins
`timescale 1ns/1ps
`include "rtc_host_cfg.svh"
module rtc_device_model (
	input  wire logic        ceN,
	input  wire logic        oeN,
	input  wire logic        weN,
	input  wire logic [18:0] memAddr,
	input  wire logic        dqOut,
	input  wire logic        dqOe,
	input  wire logic        powerOkPin,
	input  wire logic        devRstN,
	output logic             dqIn
);
	localparam logic [63:0] PATTERN   = `UNLOCK_PATTERN;
	localparam logic [63:0] ZERO_MASK = 64'h00E0C0C840808000;
	logic [63:0] img       = 64'h0;
	logic [18:0] lastAddr  = 19'h0;
	logic [6:0]  ptr       = 7'h0;
	logic [6:0]  xcnt      = 7'h0;
	logic        fail      = 1'b1;
	logic        unlocked  = 1'b0;
	logic        wSeen     = 1'b0;
	logic        rSeen     = 1'b0;
	logic        wBit      = 1'b0;
	logic        lastBit   = 1'b0;
	int          unlocks   = 0;
	int          memWrites = 0;
	int          rstPulses = 0;
	int          cycles    = 0;
	wire devDrive = !ceN && !oeN && unlocked && powerOkPin;
	wire outBit = img[xcnt[5:0]];
	// Released line shows the inverse of the last bit, not a stale copy
	assign dqIn = dqOe ? dqOut : (devDrive ? outBit : ~lastBit);
	// Note what kind of cycle is under way
	always @(ceN or oeN or weN or dqIn) begin
		if (!ceN && !weN) begin
			wSeen = 1'b1;
			wBit = dqIn;
		end
		if (!ceN && !oeN) rSeen = 1'b1;
		if (devDrive) lastBit = outBit;
	end
	// Act when chip enable ends the cycle; only this block's enable counts
	always @(posedge ceN) begin
		if (powerOkPin) begin
			cycles++;
			if (unlocked) begin
				if (wSeen) img[xcnt[5:0]] = wBit & ~ZERO_MASK[xcnt[5:0]];
				xcnt++;
				if (xcnt == 7'h40) unlocked = 1'b0;
			end else if (rSeen) begin
				ptr = 7'h0;
				fail = 1'b0;
			end else if (wSeen) begin
				memWrites++;
				lastAddr = memAddr;
				if (!fail && wBit === PATTERN[ptr[5:0]]) ptr++;
				else fail = 1'b1;
				if (ptr == 7'h40) begin
					unlocked = 1'b1;
					xcnt = 7'h0;
					fail = 1'b1;
					unlocks++;
				end
			end
		end
		wSeen = 1'b0;
		rSeen = 1'b0;
	end
	// Reset pin aborts a transfer unless masked
	always @(negedge devRstN) begin
		rstPulses++;
		if (!img[36]) begin
			unlocked = 1'b0;
			fail = 1'b1;
		end
	end
endmodule

// [bench/rtc_host_ctrl_properties.sv]
// Pin-level checks on the serial clock access controller
`timescale 1ns/1ps
module rtc_host_ctrl_properties (
	input wire logic        clk,
	input wire logic        rst,
	input wire logic        ceN,
	input wire logic        oeN,
	input wire logic        weN,
	input wire logic [18:0] memAddr,
	input wire logic        dqOut,
	input wire logic        dqOe,
	input wire logic        powerOkPin,
	input wire logic        devRstN
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// ----
	// Power loss counter
	// ----
	logic [3:0] lowCnt_reg;
	logic [3:0] lowCnt_next;
	// Saturates so a long outage stays flagged
	always_comb begin
		lowCnt_next = lowCnt_reg;
		if (powerOkPin) lowCnt_next = 4'h0;
		else if (lowCnt_reg != 4'hF) lowCnt_next = lowCnt_reg + 4'h1;
	end
	always_ff @(posedge clk) begin
		lowCnt_reg <= rst ? 4'h0 : lowCnt_next;
	end
	// ----
	// Bus cycle shapes
	// ----
	sequence wrStrobe;
		(!weN && !ceN)[*2] ##1 (weN && ceN);
	endsequence
	sequence rdStrobe;
		(!oeN && !ceN)[*5] ##1 (oeN && ceN);
	endsequence
	chk_write_strobe: assert property ($fell(weN) |-> wrStrobe)
		else $error("write strobe length wrong");
	chk_read_strobe: assert property ($fell(oeN) |-> rdStrobe)
		else $error("read strobe length wrong");
	chk_one_strobe: assert property (oeN || weN)
		else $error("read and write strobes together");
	chk_ce_pairs: assert property (ceN == (oeN && weN))
		else $error("chip enable not paired with a strobe");
	chk_no_fight: assert property (!oeN |-> !dqOe)
		else $error("host drives data during read");
	chk_write_held: assert property (!weN |-> dqOe && $stable(memAddr) && $stable(dqOut))
		else $error("write data or address moved");
	chk_power_block: assert property (lowCnt_reg >= 4'hC |-> ceN)
		else $error("access while power is low");
	chk_devrst_len: assert property ($fell(devRstN) |=> !devRstN ##1 devRstN)
		else $error("device reset pulse length wrong");
endmodule

// [bench/test_rtc_host_ctrl.sv]
// Self-checking bench for the serial clock access controller
`timescale 1ns/1ps
`include "rtc_host_cfg.svh"
`define CHECK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin error_cnt++; \
	$display("BAD t=%0t got=%h exp=%h", $time, got, exp); end end
module test_rtc_host_ctrl;
	localparam logic [31:0] IMG_LO = 32'hB259D999; // 12-hour PM, BCD fields
	localparam logic [31:0] IMG_HI = 32'h26123185; // Oscillator on, day 5
	localparam logic [63:0] EXP    = {IMG_HI, IMG_LO} & ~64'h00E0C0C840808000;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [7:0]  regAddr = 8'h00;
	logic [31:0] regWdata = 32'h0;
	logic        regWr = 1'b0;
	logic        regRd = 1'b0;
	logic        powerOkPin = 1'b1;
	logic [31:0] regRdata;
	logic [31:0] d;
	logic [18:0] memAddr;
	logic        ceN, oeN, weN, dqOut, dqOe, dqIn, devRstN, busy;
	int          error_cnt = 0;
	int          samples_checked = 0;
	int          c;
	always #25 clk = ~clk;
	rtc_host_ctrl uut (.clk(clk), .rst(rst), .clkEn(1'b1), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
		.ceN(ceN), .oeN(oeN), .weN(weN), .memAddr(memAddr), .dqOut(dqOut),
		.dqOe(dqOe), .dqIn(dqIn), .powerOkPin(powerOkPin), .devRstN(devRstN),
		.busy(busy));
	rtc_device_model dev (.ceN(ceN), .oeN(oeN), .weN(weN), .memAddr(memAddr),
		.dqOut(dqOut), .dqOe(dqOe), .powerOkPin(powerOkPin), .devRstN(devRstN),
		.dqIn(dqIn));
	// ----
	// Register bus tasks
	// ----
	task automatic regWrite(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		regAddr <= a;
		regWdata <= v;
		regWr <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
	endtask
	// Data stand only in the cycle after the strobe
	task automatic regRead(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
		#1 v = regRdata;
	endtask
	task automatic runOp(input logic [31:0] ctrl);
		int n = 0;
		regWrite(`REG_CTRL, ctrl);
		do begin
			regRead(`REG_STATUS, d);
			n++;
		end while (d[`STAT_DONE] !== 1'b1 && n < 3000);
		`CHECK(d[`STAT_DONE], 1'b1);
		regWrite(`REG_STATUS, 32'h2);
	endtask
	// ----
	// Scenarios
	// ----
	task automatic testReset();
		regRead(`REG_STATUS, d);
		`CHECK(d, 32'h8);
		regRead(`REG_SCRATCH, d);
		`CHECK(d, 32'h7FFFF);
		regRead(8'h14, d);
		`CHECK(d, 32'h0);
		regWrite(`REG_SCRATCH, 32'h00123);
		$display("reset test done");
	endtask
	task automatic testWriteClock();
		regWrite(`REG_IMAGE_LO, IMG_LO);
		regWrite(`REG_IMAGE_HI, IMG_HI);
		runOp(32'h2);
		`CHECK(dev.img, EXP);
		`CHECK(dev.unlocks, 1);
		`CHECK(dev.memWrites, 64);
		`CHECK(dev.lastAddr, 19'h00123);
		$display("clock write test done");
	endtask
	task automatic testReadClock();
		regWrite(`REG_IMAGE_LO, 32'h0);
		regWrite(`REG_IMAGE_HI, 32'h0);
		runOp(32'h1);
		regRead(`REG_IMAGE_LO, d);
		`CHECK(d, EXP[31:0]);
		regRead(`REG_IMAGE_HI, d);
		`CHECK(d, EXP[63:32]);
		`CHECK(dev.unlocked, 1'b0);
		$display("clock read test done");
	endtask
	// Second command and image write land while busy
	task automatic testRefuse();
		regWrite(`REG_CTRL, 32'h2);
		regWrite(`REG_CTRL, 32'h1);
		`CHECK(busy, 1'b1);
		regWrite(`REG_IMAGE_LO, 32'h0);
		runOp(32'h0);
		regRead(`REG_STATUS, d);
		`CHECK(d, 32'hC);
		`CHECK(busy, 1'b0);
		regWrite(`REG_STATUS, 32'h4);
		regRead(`REG_IMAGE_LO, d);
		`CHECK(d, EXP[31:0]);
		`CHECK(dev.unlocks, 3);
		$display("refusal test done");
	endtask
	task automatic testPower();
		@(posedge clk);
		powerOkPin <= 1'b0;
		repeat (8) @(posedge clk);
		regRead(`REG_STATUS, d);
		`CHECK(d, 32'h0);
		c = dev.cycles;
		regWrite(`REG_CTRL, 32'h1);
		repeat (20) @(posedge clk);
		`CHECK(dev.cycles, c);
		regRead(`REG_STATUS, d);
		`CHECK(d, 32'h4);
		regWrite(`REG_STATUS, 32'h4);
		powerOkPin <= 1'b1;
		repeat (8) @(posedge clk);
		// Supply drops during the unlock writes: sequence ends, refused set
		regWrite(`REG_CTRL, 32'h1);
		repeat (100) @(posedge clk);
		powerOkPin <= 1'b0;
		repeat (30) @(posedge clk);
		regRead(`REG_STATUS, d);
		`CHECK(d, 32'h4);
		`CHECK(busy, 1'b0);
		regWrite(`REG_STATUS, 32'h4);
		powerOkPin <= 1'b1;
		repeat (8) @(posedge clk);
		$display("power test done");
	endtask
	// Reset wins over read; a pulse alone never sets the done flag
	task automatic testDevReset();
		regWrite(`REG_CTRL, 32'h5);
		repeat (6) @(posedge clk);
		`CHECK(dev.rstPulses, 1);
		regRead(`REG_STATUS, d);
		`CHECK(d, 32'h8);
		runOp(32'h1);
		regRead(`REG_IMAGE_HI, d);
		`CHECK(d, EXP[63:32]);
		$display("device reset test done");
	endtask
	task automatic summarize();
		$display("checks=%0d mismatches=%0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		repeat (8) @(posedge clk);
		testReset();
		testWriteClock();
		testReadClock();
		testRefuse();
		testPower();
		testDevReset();
		summarize();
	end
	// Watchdog well beyond six clock operations
	initial begin
		#(50 * 40000);
		error_cnt++;
		summarize();
	end
endmodule
bind rtc_host_ctrl rtc_host_ctrl_properties chk (.clk(clk), .rst(rst), .ceN(ceN),
	.oeN(oeN), .weN(weN), .memAddr(memAddr), .dqOut(dqOut), .dqOe(dqOe),
	.powerOkPin(powerOkPin), .devRstN(devRstN));

// [hdl/rtc_host_cfg.svh]
// Constants for the serial clock access controller
//
// Operation
// - Unlock needs 64 matching pattern writes on bit 0
// - Start unlock with one read cycle
// - Unlock writes use one scratch address
// - Pattern sent least significant bit first
// - Eight registers, bit 0 reg 0 first
// - Transfer every register as whole bytes
`ifndef RTC_HOST_CFG_SVH
`define RTC_HOST_CFG_SVH

// ----------------------------------------------------------------
// Software register map
// ----------------------------------------------------------------
`define REG_CTRL      8'h00
`define REG_STATUS    8'h04
`define REG_IMAGE_LO  8'h08
`define REG_IMAGE_HI  8'h0C
`define REG_SCRATCH   8'h10

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CTRL_READ     0
`define CTRL_WRITE    1
`define CTRL_DEVRST   2
`define STAT_BUSY     0
`define STAT_DONE     1
`define STAT_REFUSED  2
`define STAT_POWEROK  3

// ----------------------------------------------------------------
// Reset values and sizes
// ----------------------------------------------------------------
`define MEM_ADDR_W    19
`define SCRATCH_RST   19'h7FFFF
`define XFER_BITS     7'h40
`define UNLOCK_PATTERN 64'h5CA33AC55CA33AC5

// ----------------------------------------------------------------
// Timing, clock period 50 ns
// ----------------------------------------------------------------
`define CLK_NS        50
`define STROBE_NS     65
`define RECOV_NS      20
`define DEVRST_NS     85
`define STROBE_CYC    ((`STROBE_NS + `CLK_NS - 1) / `CLK_NS)
`define RECOV_CYC     ((`RECOV_NS + `CLK_NS - 1) / `CLK_NS)
`define DEVRST_CYC    ((`DEVRST_NS + `CLK_NS - 1) / `CLK_NS)
`define SYNC_LAT      3

`endif

// [hdl/rtc_host_ctrl.sv]
// Host controller that unlocks and transfers the serial clock image
`timescale 1ns/1ps
`include "rtc_host_cfg.svh"
module rtc_host_ctrl
	import rtc_host_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        clkEn,
	input  wire logic [7:0]  regAddr,
	input  wire logic [31:0] regWdata,
	input  wire logic        regWr,
	input  wire logic        regRd,
	output logic [31:0]      regRdata,
	output logic             ceN,
	output logic             oeN,
	output logic             weN,
	output logic [18:0]      memAddr,
	output logic             dqOut,
	output logic             dqOe,
	input  wire logic        dqIn,
	input  wire logic        powerOkPin,
	output logic             devRstN,
	output logic             busy
);
	localparam logic [63:0] PATTERN  = `UNLOCK_PATTERN; // Fixed, not secret
	localparam logic [6:0]  LASTBIT  = 7'(`XFER_BITS - 1);
	localparam logic [1:0]  RST_CYC  = 2'(`DEVRST_CYC);

	sram_cycle_if cyc();

	seq_state_t  state_reg, state_next;
	logic [6:0]  bitIdx_reg, bitIdx_next;
	logic [63:0] image_reg, image_next;
	logic [18:0] scratch_reg, scratch_next;
	logic        dirWrite_reg, dirWrite_next;
	logic        issued_reg, issued_next;
	logic        done_reg, done_next;
	logic        refused_reg, refused_next;
	logic [1:0]  rstCnt_reg, rstCnt_next;
	logic [31:0] rdata_reg, rdata_next;
	logic        p1_reg, p2_reg, p3_reg, powerOk_reg, powerOk_next;
	logic        ctrlWr, statWr, goRead, goWrite, goRst, goAny, cycEnd, powerLost;

	// ----------------------------------------------------------------
	// Cycle engine
	// ----------------------------------------------------------------
	sram_cycle_engine engine (
		.clk     (clk),
		.rst     (rst),
		.clkEn   (clkEn),
		.cyc     (cyc.slave),
		.ceN     (ceN),
		.oeN     (oeN),
		.weN     (weN),
		.memAddr (memAddr),
		.dqOut   (dqOut),
		.dqOe    (dqOe),
		.dqIn    (dqIn)
	);

	// ----------------------------------------------------------------
	// Power level synchroniser
	// ----------------------------------------------------------------
	// Filtered level only changes when the last two stages agree
	always_comb begin
		powerOk_next = (p2_reg == p3_reg) ? p3_reg : powerOk_reg;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			p1_reg      <= 1'h0;
			p2_reg      <= 1'h0;
			p3_reg      <= 1'h0;
			powerOk_reg <= 1'h0;
		end else if (clkEn) begin
			p1_reg      <= powerOkPin;
			p2_reg      <= p1_reg;
			p3_reg      <= p2_reg;
			powerOk_reg <= powerOk_next;
		end
	end

	// ----------------------------------------------------------------
	// Command decode
	// ----------------------------------------------------------------
	// Commands while busy or under power fail are refused, not queued
	always_comb begin
		ctrlWr    = regWr && (regAddr == `REG_CTRL);
		statWr    = regWr && (regAddr == `REG_STATUS);
		goRead    = ctrlWr && regWdata[`CTRL_READ];
		goWrite   = ctrlWr && regWdata[`CTRL_WRITE];
		goRst     = ctrlWr && regWdata[`CTRL_DEVRST];
		goAny     = goRead || goWrite || goRst;
		cycEnd    = issued_reg && cyc.done;
		powerLost = !powerOk_reg && !issued_reg;
	end

	// ----------------------------------------------------------------
	// Sequence control
	// ----------------------------------------------------------------
	always_comb begin
		state_next    = state_reg;
		bitIdx_next   = bitIdx_reg;
		dirWrite_next = dirWrite_reg;
		issued_next   = issued_reg;
		image_next    = image_reg;
		rstCnt_next   = rstCnt_reg;
		cyc.start     = 1'h0;
		cyc.isWrite   = 1'h0;
		cyc.addr      = scratch_reg; // All cycles on one scratch word
		cyc.wbit      = 1'h0;
		unique case (state_reg)
			S_IDLE: begin
				if (goAny && powerOk_reg) begin // Blocked device is never touched
					if (goRst) begin
						rstCnt_next = RST_CYC;
						state_next  = S_DEVRST;
					end else begin
						dirWrite_next = goWrite && !goRead;
						state_next    = S_OPEN;
					end
				end
			end
			S_OPEN: begin
				// Opening read resets the device pointer
				cyc.start   = !issued_reg && !powerLost;
				cyc.isWrite = 1'h0;
				if (cyc.start) begin
					issued_next = 1'h1;
				end
				if (cycEnd) begin
					issued_next = 1'h0;
					bitIdx_next = 7'h00;
					state_next  = S_UNLOCK;
				end
			end
			S_UNLOCK: begin
				// Unbroken writes, pattern low bit first
				cyc.start   = !issued_reg && !powerLost;
				cyc.isWrite = 1'h1;
				cyc.wbit    = PATTERN[bitIdx_reg[5:0]];
				if (cyc.start) begin
					issued_next = 1'h1;
				end
				if (cycEnd) begin
					issued_next = 1'h0;
					bitIdx_next = bitIdx_reg + 7'h01;
					if (bitIdx_reg == LASTBIT) begin
						bitIdx_next = 7'h00;
						state_next  = S_XFER;
					end
				end
			end
			S_XFER: begin
				// Reg 0 bit 0 first, every byte whole
				cyc.start   = !issued_reg && !powerLost;
				cyc.isWrite = dirWrite_reg;
				cyc.wbit    = image_reg[bitIdx_reg[5:0]];
				if (cyc.start) begin
					issued_next = 1'h1;
				end
				if (cycEnd) begin
					issued_next = 1'h0;
					if (!dirWrite_reg) begin
						image_next[bitIdx_reg[5:0]] = cyc.rbit;
					end
					bitIdx_next = bitIdx_reg + 7'h01;
					if (bitIdx_reg == LASTBIT) begin
						bitIdx_next = 7'h00;
						state_next  = S_IDLE; // Device back to plain memory
					end
				end
			end
			S_DEVRST: begin
				// Low pulse aborts a device transfer unless masked
				if (rstCnt_reg == 2'h1) begin
					state_next = S_IDLE;
				end
				rstCnt_next = rstCnt_reg - 2'h1;
			end
			default: begin
				state_next = S_IDLE;
			end
		endcase
		// Power loss between cycles drops the sequence; next one reopens
		if ((state_reg == S_OPEN || state_reg == S_UNLOCK || state_reg == S_XFER)
				&& powerLost) begin
			state_next  = S_IDLE;
			bitIdx_next = 7'h00;
		end
		// Software image loads only while no transfer runs
		if (regWr && state_reg == S_IDLE) begin
			if (regAddr == `REG_IMAGE_LO) begin
				image_next[31:0] = regWdata;
			end
			if (regAddr == `REG_IMAGE_HI) begin
				image_next[63:32] = regWdata;
			end
		end
	end

	// ----------------------------------------------------------------
	// Sticky flags and scratch address
	// ----------------------------------------------------------------
	// Hardware set beats a software clear in the same cycle
	always_comb begin
		scratch_next = scratch_reg;
		done_next    = done_reg;
		refused_next = refused_reg;
		if (regWr && regAddr == `REG_SCRATCH && state_reg == S_IDLE) begin
			scratch_next = regWdata[18:0];
		end
		if (statWr && regWdata[`STAT_DONE]) begin
			done_next = 1'h0;
		end
		if (statWr && regWdata[`STAT_REFUSED]) begin
			refused_next = 1'h0;
		end
		if (state_reg == S_XFER && cycEnd && bitIdx_reg == LASTBIT) begin
			done_next = 1'h1;
		end
		if (goAny && (state_reg != S_IDLE || !powerOk_reg)) begin
			refused_next = 1'h1;
		end
		if ((state_reg == S_OPEN || state_reg == S_UNLOCK || state_reg == S_XFER)
				&& powerLost) begin
			refused_next = 1'h1;
		end
	end

	// ----------------------------------------------------------------
	// Read data, one cycle after the strobe
	// ----------------------------------------------------------------
	always_comb begin
		rdata_next = 32'h00000000;
		if (regRd) begin
			unique case (regAddr)
				`REG_STATUS: begin
					rdata_next[`STAT_BUSY]    = (state_reg != S_IDLE);
					rdata_next[`STAT_DONE]    = done_reg;
					rdata_next[`STAT_REFUSED] = refused_reg;
					rdata_next[`STAT_POWEROK] = powerOk_reg;
				end
				`REG_IMAGE_LO: rdata_next = image_reg[31:0];
				`REG_IMAGE_HI: rdata_next = image_reg[63:32];
				`REG_SCRATCH:  rdata_next = {13'h0000, scratch_reg};
				default:       rdata_next = 32'h00000000;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// State registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			state_reg    <= S_IDLE;
			bitIdx_reg   <= 7'h00;
			image_reg    <= 64'h0000000000000000;
			scratch_reg  <= `SCRATCH_RST;
			dirWrite_reg <= 1'h0;
			issued_reg   <= 1'h0;
			done_reg     <= 1'h0;
			refused_reg  <= 1'h0;
			rstCnt_reg   <= 2'h0;
			rdata_reg    <= 32'h00000000;
		end else if (clkEn) begin
			state_reg    <= state_next;
			bitIdx_reg   <= bitIdx_next;
			image_reg    <= image_next;
			scratch_reg  <= scratch_next;
			dirWrite_reg <= dirWrite_next;
			issued_reg   <= issued_next;
			done_reg     <= done_next;
			refused_reg  <= refused_next;
			rstCnt_reg   <= rstCnt_next;
			rdata_reg    <= rdata_next;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	always_comb begin
		regRdata = rdata_reg;
		devRstN  = (state_reg != S_DEVRST);
		busy     = (state_reg != S_IDLE);
	end
endmodule

// [hdl/rtc_host_pkg.sv]
// Types shared by the serial clock access controller
package rtc_host_pkg;
	typedef enum logic [2:0] {
		S_IDLE   = 3'b000,
		S_OPEN   = 3'b001,
		S_UNLOCK = 3'b010,
		S_XFER   = 3'b011,
		S_DEVRST = 3'b100
	} seq_state_t;

	typedef enum logic [1:0] {
		E_IDLE   = 2'b00,
		E_SETUP  = 2'b01,
		E_STROBE = 2'b10,
		E_RECOV  = 2'b11
	} cyc_state_t;
endpackage

// [hdl/sram_cycle_engine.sv]
// One chip-enable bus cycle on the SRAM pins, read or write
`timescale 1ns/1ps
`include "rtc_host_cfg.svh"
module sram_cycle_engine
	import rtc_host_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        clkEn,
	sram_cycle_if.slave      cyc,
	output logic             ceN,
	output logic             oeN,
	output logic             weN,
	output logic [18:0]      memAddr,
	output logic             dqOut,
	output logic             dqOe,
	input  wire logic        dqIn
);
	localparam logic [2:0] STROBE_RD = 3'(`STROBE_CYC + `SYNC_LAT);
	localparam logic [2:0] STROBE_WR = 3'(`STROBE_CYC);
	localparam logic [2:0] RECOV     = 3'(`RECOV_CYC);

	cyc_state_t  state_reg, state_next;
	logic [2:0]  cnt_reg, cnt_next;
	logic        isWrite_reg, isWrite_next;
	logic [18:0] addr_reg, addr_next;
	logic        wbit_reg, wbit_next;
	logic        rbit_reg, rbit_next;
	logic        s1_reg, s2_reg, s3_reg, pin_reg, pin_next;

	// ----------------------------------------------------------------
	// Data pin synchroniser
	// ----------------------------------------------------------------
	// Pin value moves only when the last two stages agree
	always_comb begin
		pin_next = (s2_reg == s3_reg) ? s3_reg : pin_reg;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s1_reg  <= 1'h0;
			s2_reg  <= 1'h0;
			s3_reg  <= 1'h0;
			pin_reg <= 1'h0;
		end else if (clkEn) begin
			s1_reg  <= dqIn;
			s2_reg  <= s1_reg;
			s3_reg  <= s2_reg;
			pin_reg <= pin_next;
		end
	end

	// ----------------------------------------------------------------
	// Cycle sequencer
	// ----------------------------------------------------------------
	// Reads hold the strobe longer to cover the synchroniser delay
	always_comb begin
		state_next   = state_reg;
		cnt_next     = cnt_reg;
		isWrite_next = isWrite_reg;
		addr_next    = addr_reg;
		wbit_next    = wbit_reg;
		rbit_next    = rbit_reg;
		unique case (state_reg)
			E_IDLE: begin
				if (cyc.start) begin
					isWrite_next = cyc.isWrite;
					addr_next    = cyc.addr;
					wbit_next    = cyc.wbit;
					state_next   = E_SETUP;
				end
			end
			E_SETUP: begin
				cnt_next   = isWrite_reg ? STROBE_WR : STROBE_RD;
				state_next = E_STROBE;
			end
			E_STROBE: begin
				if (cnt_reg == 3'h1) begin
					if (!isWrite_reg) begin
						rbit_next = pin_reg; // Device bit on data line 0
					end
					cnt_next   = RECOV;
					state_next = E_RECOV;
				end else begin
					cnt_next = cnt_reg - 3'h1;
				end
			end
			E_RECOV: begin
				if (cnt_reg == 3'h1) begin
					state_next = E_IDLE;
				end else begin
					cnt_next = cnt_reg - 3'h1;
				end
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_reg   <= E_IDLE;
			cnt_reg     <= 3'h0;
			isWrite_reg <= 1'h0;
			addr_reg    <= 19'h00000;
			wbit_reg    <= 1'h0;
			rbit_reg    <= 1'h0;
		end else if (clkEn) begin
			state_reg   <= state_next;
			cnt_reg     <= cnt_next;
			isWrite_reg <= isWrite_next;
			addr_reg    <= addr_next;
			wbit_reg    <= wbit_next;
			rbit_reg    <= rbit_next;
		end
	end

	// ----------------------------------------------------------------
	// Pin drive
	// ----------------------------------------------------------------
	// Data held through recovery so hold time is met after the strobe
	always_comb begin
		ceN      = (state_reg != E_STROBE);
		oeN      = !((state_reg == E_STROBE) && !isWrite_reg);
		weN      = !((state_reg == E_STROBE) && isWrite_reg);
		memAddr  = addr_reg;
		dqOut    = wbit_reg;
		dqOe     = isWrite_reg && (state_reg != E_IDLE);
		cyc.done = (state_reg == E_RECOV) && (cnt_reg == 3'h1);
		cyc.rbit = rbit_reg;
	end
endmodule

// [hdl/sram_cycle_if.sv]
// Request and answer of one SRAM bus cycle
`timescale 1ns/1ps
interface sram_cycle_if;
	logic        start;
	logic        isWrite;
	logic [18:0] addr;
	logic        wbit;
	logic        done;
	logic        rbit;

	modport master (output start, output isWrite, output addr, output wbit,
		input done, input rbit);
	modport slave (input start, input isWrite, input addr, input wbit,
		output done, output rbit);
endinterface
